// File: hdl/cfa_fifo.v
// cfa_fifo.v: small synchronous fifo, valid/ready on both sides
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module cfa_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   // ==========================================
   // storage and pointers
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;
   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         // pointers wrap naturally, depth is a power of two
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/cfa_map.vh
// cfa_map.vh: register offsets, field positions, reset values and timing for the flash scan
// assumes: included by the scan block files only; definitions only
`ifndef CFA_MAP_VH
`define CFA_MAP_VH
// ==========================================
// register offsets on the sfr bus
`define CFA_ADDR_CTRL      8'h92
`define CFA_ADDR_FLIP      8'h95
`define CFA_ADDR_AUTO      8'h96
`define CFA_ADDR_CNT       8'h97
// ==========================================
// field positions
`define CFA_AUTO_EN_BIT    7
`define CFA_AUTO_DONE_BIT  6
`define CFA_SECT_MSB       5
// ==========================================
// reset values
`define CFA_RST_FLIP       8'h00
`define CFA_RST_AUTO       8'h40
`define CFA_RST_CNT        8'h00
// ==========================================
// geometry and timing
`define CFA_SECT_BYTES     1024
`define CFA_SECT_SHIFT     10
`define CFA_BANK_SECTS     64
`define CFA_FLASH_LAT      1
`endif

// File: hdl/cfa_scan.v
// cfa_scan.v: automatic flash crc scan front end and bit-reverse register
// assumes: sfr bus synchronous to clk, flash returns data FLASH_LAT cycles after a read
//
// Contract
// - with auto-run enabled, any crc control write starts a flash scan
// - complete flag reads 0 during scan, 1 once it ends
// - core is stalled for the whole scan
// - scan starts at byte address first-sector index times 1024
// - last sector starts at (index plus count) times 1024, inclusive
// - index and count both zero scans the whole 64kB bank
// - on 128 kB parts sectors 32-63 use the selected upper bank
// - bit-reverse register reads back each written byte mirrored
// - sector count upper two bits read zero, writes ignored
// - sector count holds six bits of sectors to include after the first one
// - auto-run register: enable bit 7, complete bit 6, first sector bits 5:0
// - every scanned sector spans exactly 1024 bytes
`timescale 1ns/1ps
`default_nettype none
`include "cfa_map.vh"
module cfa_scan #(
   parameter BIG_FLASH = 1'b0,
   parameter FIFO_DEP  = 4,
   parameter FIFO_AW   = 2
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire [7:0]  sfr_addr,
   input  wire        sfr_wr,
   input  wire        sfr_rd,
   input  wire [7:0]  sfr_wdata,
   output reg  [7:0]  sfr_rdata,
   input  wire [1:0]  code_bank_select,
   output wire        core_stall,
   output wire        flash_rd,
   output wire [16:0] flash_addr,
   input  wire [7:0]  flash_data,
   input  wire        flash_data_valid,
   output wire        crc_byte_valid,
   output wire [7:0]  crc_byte_data,
   input  wire        crc_byte_ready
);
   // ==========================================
   // states and functions
   localparam ST_IDLE  = 2'd0;
   localparam ST_FETCH = 2'd1;
   localparam ST_DRAIN = 2'd2;

   function [7:0] mirror;
      input [7:0] v;
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            mirror[i] = v[7-i];
         end
      end
   endfunction

   // ==========================================
   // registers
   reg [7:0]  flip_q;
   reg        auto_en_q;
   reg        done_q;
   reg [5:0]  first_q;
   reg [5:0]  cnt_q;
   reg [1:0]  state_q;
   reg [16:0] addr_q;
   reg [15:0] left_q;
   reg [2:0]  pend_q;
   wire       wr_ctrl;
   wire       start;
   wire       fifo_in_ready;
   wire       fifo_out_valid;
   wire [16:0] span_bytes;
   wire [6:0] last_sect;
   wire [15:0] base_addr;
   wire       room;
   wire       issue;
   wire       crc_pop;

   assign wr_ctrl = sfr_wr & (sfr_addr == `CFA_ADDR_CTRL);
   assign start   = wr_ctrl & auto_en_q & (state_q == ST_IDLE);
   assign core_stall = (state_q != ST_IDLE);

   // bytes to scan: (count+1) sectors, or whole bank when both zero
   assign last_sect  = {1'b0, first_q} + {1'b0, cnt_q};
   assign span_bytes = ((first_q == 6'd0) && (cnt_q == 6'd0)) ?
                       17'h10000 :
                       ({10'h000, ({1'b0, cnt_q} + 7'd1)} << `CFA_SECT_SHIFT);
   assign base_addr  = {first_q, 10'h000};

   // pend_q counts reads in flight plus bytes buffered, so the fifo never overflows
   assign crc_pop = fifo_out_valid & crc_byte_ready;
   assign room  = ({{(FIFO_AW){1'b0}}, pend_q} < FIFO_DEP[FIFO_AW+2:0]) & fifo_in_ready;
   assign issue = (state_q == ST_FETCH) & room;
   assign flash_rd = issue;
   // upper half of the 64k window maps to the selected bank on big parts
   assign flash_addr = (BIG_FLASH && addr_q[15]) ?
                       {code_bank_select[0], addr_q[15:0]} :
                       {1'b0, addr_q[15:0]};

   // ==========================================
   // sfr writes and scan sequencing
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flip_q    <= `CFA_RST_FLIP;
         auto_en_q <= 1'b0;
         done_q    <= 1'b1;
         first_q   <= 6'h00;
         cnt_q     <= 6'h00;
         state_q   <= ST_IDLE;
         addr_q    <= 17'h00000;
         left_q    <= 16'h0000;
         pend_q    <= 3'd0;
      end else begin
         if (sfr_wr && sfr_addr == `CFA_ADDR_FLIP) begin
            flip_q <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `CFA_ADDR_AUTO) begin
            auto_en_q <= sfr_wdata[`CFA_AUTO_EN_BIT];
            first_q   <= sfr_wdata[`CFA_SECT_MSB:0];
         end
         if (sfr_wr && sfr_addr == `CFA_ADDR_CNT) begin
            cnt_q <= sfr_wdata[`CFA_SECT_MSB:0];
         end
         pend_q <= pend_q + {2'b00, issue} - {2'b00, crc_pop};
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  done_q  <= 1'b0;
                  addr_q  <= {1'b0, base_addr};
                  // left_q counts bytes minus one; the 64k case wraps to ffff in 16 bits, addr bit 16 is not used
                  left_q  <= span_bytes[15:0] - 16'h0001;
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (issue) begin
                  addr_q <= addr_q + 17'h00001;
                  if (left_q == 16'h0000) begin
                     state_q <= ST_DRAIN;
                  end else begin
                     left_q <= left_q - 16'h0001;
                  end
               end
            end
            ST_DRAIN: begin
               if (pend_q == 3'd0) begin
                  done_q  <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // flash bytes pass through the fifo to the crc byte input
   cfa_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEP),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (flash_data_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (flash_data),
      .out_valid (fifo_out_valid),
      .out_ready (crc_byte_ready),
      .out_data  (crc_byte_data)
   );
   assign crc_byte_valid = fifo_out_valid;

   // ==========================================
   // sfr read data
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            `CFA_ADDR_FLIP: sfr_rdata <= mirror(flip_q);
            `CFA_ADDR_AUTO: sfr_rdata <= {auto_en_q, done_q, first_q};
            `CFA_ADDR_CNT:  sfr_rdata <= {2'b00, cnt_q};
            default:        sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: test/cfa_flash_model.sv
// cfa_flash_model.sv: code flash behind the scan block
// assumes: one byte back per read request, one cycle later
`timescale 1ns/1ps
`default_nettype none
module cfa_flash_model (
   input wire         clk,
   input wire         rst_n,
   input wire         flash_rd,
   input wire [16:0]  flash_addr,
   output logic [7:0] flash_data,
   output logic       flash_data_valid
);
   // ==========
   // data is an address hash; junk between bytes so stale data is caught
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_data_valid <= 1'b0;
         flash_data       <= 8'h00;
      end else begin
         flash_data_valid <= flash_rd;
         flash_data       <= flash_rd ? flash_addr[7:0] ^ flash_addr[15:8] : ~flash_data;
      end
   end
endmodule
`default_nettype wire

// File: test/cfa_scan_assertions.sv
// cfa_scan_assertions.sv: port checks of the flash scan block
// assumes: bound into cfa_scan; sfr writes are mirrored here
`timescale 1ns/1ps
`default_nettype none
module cfa_scan_chk #(
   parameter BIG_FLASH = 1'b0
) (
   input wire        clk,
   input wire        rst_n,
   input wire [7:0]  sfr_addr,
   input wire        sfr_wr,
   input wire        sfr_rd,
   input wire [7:0]  sfr_wdata,
   input wire [7:0]  sfr_rdata,
   input wire [1:0]  code_bank_select,
   input wire        core_stall,
   input wire        flash_rd,
   input wire [16:0] flash_addr
);
   // ==========
   // software view; new_q marks the first fetch of a scan
   reg         en_q, new_q;
   reg  [5:0]  st_q, cn_q;
   reg  [15:0] last_q;
   wire        go_w  = sfr_wr && sfr_addr == 8'h92 && en_q && !core_stall;
   wire [15:0] end_w = (st_q == 6'h00 && cn_q == 6'h00) ? 16'hFFFF :
                       {st_q, 10'h3FF} + {cn_q, 10'h000};
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {en_q, st_q, cn_q, last_q} <= 29'h0;
         new_q <= 1'b1;
      end else begin
         if (sfr_wr && sfr_addr == 8'h96) {en_q, st_q} <= {sfr_wdata[7], sfr_wdata[5:0]};
         if (sfr_wr && sfr_addr == 8'h97) cn_q <= sfr_wdata[5:0];
         if (flash_rd) last_q <= flash_addr[15:0];
         new_q <= core_stall ? new_q & !flash_rd : 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_start_follow: assert property (go_w |-> ##[1:2] core_stall)
      else $error("scan not started");
   a_start_cause: assert property ($rose(core_stall) |-> $past(go_w) || $past(go_w, 2))
      else $error("scan without start");
   a_first_addr: assert property (flash_rd && new_q |-> flash_addr[15:0] == {st_q, 10'h000})
      else $error("bad first address");
   a_addr_step: assert property (flash_rd && !new_q |-> flash_addr[15:0] == last_q + 16'h0001)
      else $error("fetch out of order");
   a_scan_end: assert property ($fell(core_stall) |-> last_q == end_w)
      else $error("scan ended at wrong byte");
   a_done_flag: assert property (sfr_rd && sfr_addr == 8'h96 |=> sfr_rdata[6] != $past(core_stall))
      else $error("complete flag wrong");
   a_count_read: assert property (sfr_rd && sfr_addr == 8'h97 |=> sfr_rdata == {2'b00, cn_q})
      else $error("sector count readback wrong");
   a_bank_bit: assert property (flash_rd |->
      flash_addr[16] == (BIG_FLASH && flash_addr[15] && code_bank_select[0]))
      else $error("bank bit wrong");
endmodule
bind cfa_scan cfa_scan_chk #(.BIG_FLASH(BIG_FLASH)) cfa_scan_chk_i (.clk, .rst_n, .sfr_addr,
   .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .code_bank_select, .core_stall, .flash_rd,
   .flash_addr);
`default_nettype wire

// File: test/cfa_scan_tb.sv
// cfa_scan_tb.sv: self-checking bench of the flash scan block
// assumes: design, checker and flash model compiled first
`timescale 1ns/1ps
`default_nettype none
module cfa_scan_tb;
   // ==========
   // wiring and helpers
   reg         clk, rst_n, sfr_wr, sfr_rd, rdy, slow;
   reg  [7:0]  addr, wd, v;
   reg  [1:0]  bank;
   wire [7:0]  rdata, fdat, cdat;
   wire [16:0] fadr;
   wire        stall, frd, fval, cval;
   integer     fail_count, n_checks, seed, ea, ee, i;
   cfa_scan #(.BIG_FLASH(1'b1)) cfa_scan_i (.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(wd), .sfr_rdata(rdata), .code_bank_select(bank),
      .core_stall(stall), .flash_rd(frd), .flash_addr(fadr), .flash_data(fdat),
      .flash_data_valid(fval), .crc_byte_valid(cval), .crc_byte_data(cdat),
      .crc_byte_ready(rdy));
   cfa_flash_model cfa_flash_model_i (.clk(clk), .rst_n(rst_n), .flash_rd(frd),
      .flash_addr(fadr), .flash_data(fdat), .flash_data_valid(fval));
   function integer xs(input integer s); begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
   end
   endfunction
   task chk(input [31:0] got, input [31:0] exp); begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [7:0] d); begin
      addr = a;
      wd = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1 sfr_wr = 1'b0;
      @(posedge clk) #1;
   end
   endtask
   task rd(input [7:0] a, input [7:0] e); begin
      addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #1 sfr_rd = 1'b0;
      @(posedge clk) #1 chk(rdata, e);
   end
   endtask
   // software keeps st+cn within 63 and clears enable afterwards
   task scan(input [5:0] st, input [5:0] cn); begin
      wr(8'h96, {2'b10, st});
      wr(8'h97, {2'b00, cn});
      ea = st * 1024;
      ee = (st == 0 && cn == 0) ? 65536 : (st + cn + 1) * 1024;
      wr(8'h92, 8'h00);
      chk(stall, 1);
      rd(8'h96, {2'b10, st});
      for (i = 0; i < 200000 && stall !== 1'b0; i = i + 1) @(posedge clk) #1;
      chk(ea, ee);
      rd(8'h96, {2'b11, st});
      wr(8'h96, {2'b00, st});
   end
   endtask
   task give_verdict; begin
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   end
   endtask
   // ==========
   // clock, random far side, reference stream
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      #1 rdy = slow ? seed[0] | seed[1] : 1'b1;
      bank = seed[3:2];
      seed = xs(seed);
   end
   // sampled mid-cycle: the values the design sees at the next rising edge
   always @(negedge clk) if (cval === 1'b1 && rdy === 1'b1) begin
      chk(cdat, ea[7:0] ^ ea[15:8]);
      ea = ea + 1;
   end
   // about 70k cycles expected, run capped below 100k
   initial begin
      #2400000;
      fail_count = fail_count + 1;
      give_verdict;
   end
   initial begin
      {rst_n, sfr_wr, sfr_rd, slow, addr, wd, bank} = 22'h0;
      {rdy, seed, fail_count, n_checks, ea} = {1'b1, 32'd94, 96'h0};
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(8'h96, 8'h40);
      rd(8'h95, 8'h00);
      rd(8'h97, 8'h00);
      rd(8'h90, 8'h00);
      wr(8'h97, 8'hFF);
      rd(8'h97, 8'h3F);
      wr(8'h96, 8'h3F);
      rd(8'h96, 8'h7F);
      wr(8'h92, 8'h00);
      chk(stall, 0);
      wr(8'h95, 8'hC0);
      rd(8'h95, 8'h03);
      for (i = 0; i < 8; i = i + 1) begin
         v = seed[7:0];
         wr(8'h95, v);
         rd(8'h95, {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]});
      end
      slow = 1'b1;
      scan(6'd63, 6'd0);
      scan(6'd1, 6'd1);
      slow = 1'b0;
      scan(6'd0, 6'd0);
      give_verdict;
   end
endmodule
`default_nettype wire
